// [verilog/brownout_reset_mode_control.v]
// brown-out reset mode control with apb register access
//
// Operation
// - mode 11 keeps protection on, even asleep
// - modes 11/10 hold start-up until ready, above threshold
// - mode 11 adds no wake delay
// - mode 10 protects running, not in sleep
// - mode 10 delays wake until ready and above
// - mode 01 follows software enable bit
// - mode 01 skips wake delay only if disabled, soft reset
// - protection applies only once monitor is ready
// - readable ready status bit
// - mode 01 protection unaffected by sleep
// - mode 00 always off, enable bit ignored
`timescale 1ns/1ns
`include "brownout_reset_defines.vh"

module brownout_reset_mode_control
(
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // configuration
    input wire [1:0] brownoutModeField,
    // reset cause of current start-up (power-on or brown-out)
    input wire porBorStart,
    // sleep control from the core
    input wire sleepReq,
    input wire wakeReq,
    // analog monitor, asynchronous
    input wire monitorReady,
    input wire supplyAbove,
    // monitor control
    output reg monitorEnable,
    output reg brownoutReset,
    // core run control
    output reg startupHold,
    output reg inSleep,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr
);

    // ************************************************
    // states
    // ************************************************
    localparam [3:0] ST_START = 4'h1;
    localparam [3:0] ST_RUN = 4'h2;
    localparam [3:0] ST_SLEEP = 4'h4;
    localparam [3:0] ST_WAKE = 4'h8;

    // ************************************************
    // synchronisers for analog inputs
    // ************************************************
    reg [1:0] readySync_reg;
    reg [1:0] aboveSync_reg;
    wire monReady;
    wire monAbove;

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            readySync_reg <= 2'h0;
            aboveSync_reg <= 2'h0;
        end
        else
        begin
            readySync_reg <= {readySync_reg[0], monitorReady};
            aboveSync_reg <= {aboveSync_reg[0], supplyAbove};
        end
    end

    assign monReady = readySync_reg[1];
    assign monAbove = aboveSync_reg[1];

    // ************************************************
    // mode decode
    // ************************************************
    wire modeOn;
    wire modeNoSleep;
    wire modeSoft;

    // the field is a static strap; mode 00 is whatever matches none of these
    assign modeOn = (brownoutModeField == `BOR_MODE_ON);
    assign modeNoSleep = (brownoutModeField == `BOR_MODE_NOSLEEP);
    assign modeSoft = (brownoutModeField == `BOR_MODE_SOFT);

    // ************************************************
    // apb decode
    // ************************************************
    wire apbWrite;
    wire apbRead;
    wire ctrlSel;
    wire statSel;

    assign apbWrite = psel && penable && pwrite;
    assign apbRead = psel && !penable && !pwrite;
    assign ctrlSel = (paddr == `BOR_CTRL_OFF);
    assign statSel = (paddr == `BOR_STAT_OFF);
    // zero wait states; unmapped addresses read zero and do not error
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // ************************************************
    // software enable
    // ************************************************
    reg softEnable_reg;
    reg softEnable_next;

    // only bit 0 of the control word is writable; the ready bit is read only
    always @*
    begin
        softEnable_next = softEnable_reg;
        if (apbWrite && ctrlSel)
            softEnable_next = pwdata[`BOR_SOFT_EN_BIT];
    end

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            softEnable_reg <= `BOR_SOFT_EN_RST;
        else
            softEnable_reg <= softEnable_next;
    end

    // ************************************************
    // start-up cause
    // ************************************************
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg softStart_reg;
    reg softStart_next;

    // latched while starting, so a later change of the cause input cannot
    // shorten a wake delay that belongs to the current start-up
    always @*
    begin
        softStart_next = softStart_reg;
        if (state_reg == ST_START)
            softStart_next = !porBorStart;
    end

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            softStart_reg <= 1'b0;
        else
            softStart_reg <= softStart_next;
    end

    // ************************************************
    // protection enable
    // ************************************************
    reg protectOn;

    always @*
    begin
        if (modeOn)
            protectOn = 1'b1;
        else if (modeNoSleep)
            protectOn = (state_reg != ST_SLEEP);
        else if (modeSoft)
            protectOn = softEnable_reg;
        else
            protectOn = 1'b0;
    end

    // ************************************************
    // sequencer
    // ************************************************
    wire monitorOk;
    reg wakeDelayed;
    reg startGated;

    assign monitorOk = monReady && monAbove;

    // soft mode skips the wake check only when disabled after a soft start
    always @*
    begin
        if (modeOn)
            wakeDelayed = 1'b0;
        else if (modeNoSleep)
            wakeDelayed = 1'b1;
        else if (modeSoft)
            wakeDelayed = softEnable_reg || !softStart_reg;
        else
            wakeDelayed = 1'b0;
    end

    // soft mode gates start-up too while enabled, so a set bit always protects
    always @*
    begin
        if (modeOn)
            startGated = 1'b1;
        else if (modeNoSleep)
            startGated = 1'b1;
        else if (modeSoft)
            startGated = softEnable_reg;
        else
            startGated = 1'b0;
    end

    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_START:
            begin
                if (!startGated || monitorOk)
                    state_next = ST_RUN;
            end
            ST_RUN:
            begin
                if (sleepReq)
                    state_next = ST_SLEEP;
            end
            ST_SLEEP:
            begin
                if (wakeReq)
                    state_next = wakeDelayed ? ST_WAKE : ST_RUN;
            end
            ST_WAKE:
            begin
                if (monitorOk)
                    state_next = ST_RUN;
            end
            default:
            begin
                state_next = ST_START;
            end
        endcase
    end

    // a brown-out reset sends the sequence back to the start check
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            state_reg <= ST_START;
        else if (brownoutReset)
            state_reg <= ST_START;
        else
            state_reg <= state_next;
    end

    // ************************************************
    // outputs
    // ************************************************
    wire protectLive;
    wire monitorEnable_next;
    wire brownoutReset_next;
    wire startupHold_next;
    wire inSleep_next;

    // a monitor that is not ready yet must not trip the reset
    assign protectLive = protectOn && monReady;

    // monitor powered when protecting or when a start or wake check needs it
    assign monitorEnable_next = protectOn || state_next == ST_WAKE || state_next == ST_START;
    assign brownoutReset_next = protectLive && !monAbove;
    assign startupHold_next = (state_next == ST_START) || (state_next == ST_WAKE);
    assign inSleep_next = (state_next == ST_SLEEP);

    // outputs are registered so the core and monitor never see decode glitches
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            monitorEnable <= 1'b0;
        else
            monitorEnable <= monitorEnable_next;
    end

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            brownoutReset <= 1'b0;
        else
            brownoutReset <= brownoutReset_next;
    end

    // the hold stays set through reset so the core cannot run ahead of the check
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            startupHold <= 1'b1;
        else
            startupHold <= startupHold_next;
    end

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            inSleep <= 1'b0;
        else
            inSleep <= inSleep_next;
    end

    // ************************************************
    // read data
    // ************************************************
    reg [31:0] readWord;

    // captured in the setup phase and held through the access phase
    always @*
    begin
        readWord = 32'h0;
        case (paddr)
            `BOR_CTRL_OFF:
            begin
                readWord[`BOR_SOFT_EN_BIT] = softEnable_reg;
                readWord[`BOR_READY_BIT] = monReady;
            end
            `BOR_STAT_OFF:
            begin
                readWord[`BOR_STAT_READY_BIT] = monReady;
                readWord[`BOR_STAT_ACTIVE_BIT] = protectLive;
                readWord[`BOR_STAT_RESET_BIT] = brownoutReset;
                readWord[`BOR_STAT_HOLD_BIT] = startupHold;
                readWord[`BOR_STAT_MODE_LSB + 1:`BOR_STAT_MODE_LSB] = brownoutModeField;
            end
            default:
                readWord = 32'h0;
        endcase
    end

    // the status select is kept for future read-side qualifiers
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            prdata <= 32'h0;
        else if (apbRead && (ctrlSel || statSel))
            prdata <= readWord;
        else if (apbRead)
            prdata <= 32'h0;
    end

endmodule // brownout_reset_mode_control

// [verilog/brownout_reset_defines.vh]
// constants for the brown-out reset mode control block
`ifndef BROWNOUT_RESET_DEFINES_VH
`define BROWNOUT_RESET_DEFINES_VH

// register byte offsets
`define BOR_CTRL_OFF 12'h000
`define BOR_STAT_OFF 12'h004

// brownout_control_reg fields
`define BOR_SOFT_EN_BIT 0
`define BOR_READY_BIT 31

// status register fields
`define BOR_STAT_READY_BIT 0
`define BOR_STAT_ACTIVE_BIT 1
`define BOR_STAT_RESET_BIT 2
`define BOR_STAT_HOLD_BIT 3
`define BOR_STAT_MODE_LSB 4

// reset values
`define BOR_SOFT_EN_RST 1'h0

// brownout_mode_field encodings
`define BOR_MODE_OFF 2'h0
`define BOR_MODE_SOFT 2'h1
`define BOR_MODE_NOSLEEP 2'h2
`define BOR_MODE_ON 2'h3

`endif

// [tb/brownout_monitor_model.sv]
// stand-in for the analog supply monitor: settles, then compares
`timescale 1ns/1ns
module brownout_monitor_model
(
    input wire clk_sys, monitorEnable, supplyOk,
    input wire [7:0] settleCycles,
    output reg monitorReady = 1'b0,
    output reg supplyAbove = 1'b0
);
    int cnt = 0;
    // unpowered, the comparator output means nothing, so it toggles
    always @(posedge clk_sys)
    begin
        cnt <= monitorEnable ? cnt + 1 : 0;
        monitorReady <= monitorEnable && cnt >= settleCycles;
        supplyAbove <= (monitorEnable && cnt >= settleCycles) ? supplyOk : !supplyAbove;
    end
endmodule // brownout_monitor_model

// [tb/brownout_reset_mode_control_checker.sv]
// port assertions for the brown-out mode control block
`timescale 1ns/1ns
module brownout_reset_mode_control_checker
(
    input wire clk_sys, rstn, wakeReq, monitorReady, supplyAbove,
    input wire [1:0] brownoutModeField,
    input wire monitorEnable, brownoutReset, startupHold, inSleep, pready, pslverr
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_drop;
        brownoutModeField == 2'h3 && !startupHold && monitorReady && $fell(supplyAbove);
    endsequence
    sequence s_low;
        (!supplyAbove && monitorReady)[*3];
    endsequence
    a_drop_resets: assert property (s_drop ##1 s_low |-> ##[0:1] brownoutReset)
        else $error("no reset after drop");
    a_start_gated: assert property ($fell(startupHold) && brownoutModeField[1]
        |-> $past(monitorReady, 3) && $past(supplyAbove, 3)) else $error("early start");
    a_wake_direct: assert property (brownoutModeField == 2'h3 && inSleep && wakeReq
        |=> (!startupHold)[*3] ##0 !inSleep) else $error("wake delayed");
    a_wake_held: assert property (brownoutModeField == 2'h2 && inSleep && wakeReq
        && !monitorReady |-> ##[1:3] startupHold) else $error("wake not held");
    a_ready_first: assert property ((!monitorReady)[*5] |-> !brownoutReset)
        else $error("reset before ready");
    a_off_mode: assert property ((brownoutModeField == 2'h0)[*2]
        |-> !monitorEnable && !brownoutReset) else $error("off mode active");
    a_sleep_on: assert property (inSleep && brownoutModeField == 2'h3 |-> monitorEnable)
        else $error("monitor off in sleep");
    a_apb_ok: assert property (pready && !pslverr) else $error("apb answer");
endmodule // brownout_reset_mode_control_checker

// [tb/brownout_reset_mode_control_tb_top.sv]
// self-checking bench for the brown-out mode control block
`timescale 1ns/1ns
module brownout_reset_mode_control_tb_top;
    logic clk_sys = 0, rstn = 0, porBorStart = 1, sleepReq = 0, wakeReq = 0, supplyOk = 1;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [1:0] brownoutModeField = 2'h3;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, q;
    logic [7:0] settleCycles = 8'h20;
    wire monitorReady, supplyAbove, monitorEnable, brownoutReset, startupHold, inSleep;
    wire pready, pslverr;
    wire [31:0] prdata;
    int mismatches = 0, tests_run = 0, m;
    integer seed = 32'h3ad0;
    always #2 clk_sys = !clk_sys;
    brownout_reset_mode_control dut (.*);
    brownout_monitor_model monitor (.*);
    task automatic close_out(input int fail);
        mismatches += fail;
        if (mismatches == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // called just after an edge; one idle edge after release keeps drivers race free
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge clk_sys);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
        if (n == 20)
            close_out(1);
    endtask
    task automatic wait_run;
        int n;
        for (n = 0; n < 300 && startupHold !== 1'b0; n++)
            @(posedge clk_sys);
        if (n == 300)
            close_out(1);
    endtask
    initial
    begin
        for (m = 0; m < 4; m++)
        begin
            rstn <= 1'b0;
            brownoutModeField <= m[1:0];
            porBorStart <= (m != 1);
            supplyOk <= 1'b1;
            settleCycles <= {3'h1, 5'($random(seed))};
            repeat (3) @(posedge clk_sys);
            rstn <= 1'b1;
            repeat (20) @(posedge clk_sys);
            check(startupHold, m > 1);
            wait_run;
            apb(1'b0, 12'h004, 32'h0);
            check(q[5:0], {m[1:0], 2'h0, m > 1, monitorReady});
            apb(1'b1, 12'h000, 32'($random(seed)) | 32'h1);
            apb(1'b0, 12'h000, 32'h0);
            check(q, {monitorReady, 30'h0, 1'b1});
            apb(1'b0, 12'h008, 32'h0);
            check(q, 32'h0);
            repeat (50) @(posedge clk_sys);
            check(monitorEnable, m != 0);
            sleepReq <= 1'b1;
            @(posedge clk_sys);
            sleepReq <= 1'b0;
            repeat (60) @(posedge clk_sys);
            check(monitorEnable, m == 1 || m == 3);
            check(inSleep, 1'b1);
            wakeReq <= 1'b1;
            @(posedge clk_sys);
            wakeReq <= 1'b0;
            repeat (3) @(posedge clk_sys);
            if (m != 1)
                check(startupHold, m == 2);
            wait_run;
            supplyOk <= 1'b0;
            repeat (8) @(posedge clk_sys);
            check(brownoutReset, m != 0);
        end
        close_out(0);
    end
endmodule // brownout_reset_mode_control_tb_top
bind brownout_reset_mode_control brownout_reset_mode_control_checker chk (.*);
